/* File: pkg/flow_pkg.sv */
// shared constants and types for the branch and compare decoder
package flow_pkg;
	// opcode fields
	localparam logic [3:0] BRANCH_GROUP = 4'h6;
	localparam logic [3:0] COMPARE_GROUP = 4'hb;
	localparam logic [3:0] COND_ALWAYS = 4'h0;
	localparam logic [3:0] COND_SUBROUTINE = 4'h1;
	localparam logic [7:0] DISP_WORD_CODE = 8'h00;
	localparam logic [7:0] DISP_LONG_CODE = 8'hff;
	localparam logic [2:0] SIZE_BYTE = 3'h0;
	localparam logic [2:0] SIZE_WORD = 3'h1;
	localparam logic [2:0] SIZE_LONG = 3'h2;
	// address arithmetic
	localparam logic [31:0] BASE_OFFSET = 32'h0000_0002;
	localparam logic [31:0] STACK_STEP = 32'h0000_0004;
	localparam logic [31:0] EXT_STEP = 32'h0000_0002;
	// reset values
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] SP_RESET = 32'h0000_0000;
	localparam logic [4:0] CCR_RESET = 5'h00;

	// condition-code flags
	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} ccr_t;

	// one word from the fetch stream
	typedef struct packed {
		logic valid;
		logic [15:0] word;
	} fetch_t;

	// stack write request
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [31:0] data;
	} push_t;

	// compare operands
	typedef struct packed {
		logic [2:0] size;
		logic [31:0] dst;
		logic [31:0] src;
	} cmp_req_t;
endpackage

/* File: logic/cond_test.sv */
// condition selector evaluation for conditional branches
`timescale 1ns/1ps
module cond_test (
	input wire logic [3:0] COND_I, // condition selector
	input wire flow_pkg::ccr_t CCR_I, // current flags
	output logic TRUE_O // selected test holds
);
	import flow_pkg::*;

	// one test per code, customary encoding
	always_comb begin
		unique case (COND_I)
			4'h0: TRUE_O = 1'b1; // always
			4'h1: TRUE_O = 1'b0; // subroutine code, not a test
			4'h2: TRUE_O = ~CCR_I.c & ~CCR_I.z; // high
			4'h3: TRUE_O = CCR_I.c | CCR_I.z; // low or same
			4'h4: TRUE_O = ~CCR_I.c; // carry clear
			4'h5: TRUE_O = CCR_I.c; // carry set
			4'h6: TRUE_O = ~CCR_I.z; // not equal
			4'h7: TRUE_O = CCR_I.z; // equal
			4'h8: TRUE_O = ~CCR_I.v; // overflow clear
			4'h9: TRUE_O = CCR_I.v; // overflow set
			4'ha: TRUE_O = ~CCR_I.n; // plus
			4'hb: TRUE_O = CCR_I.n; // minus
			4'hc: TRUE_O = ~(CCR_I.n ^ CCR_I.v); // greater or equal
			4'hd: TRUE_O = CCR_I.n ^ CCR_I.v; // less than
			4'he: TRUE_O = ~CCR_I.z & ~(CCR_I.n ^ CCR_I.v); // greater than
			4'hf: TRUE_O = CCR_I.z | (CCR_I.n ^ CCR_I.v); // less or equal
		endcase
	end
endmodule

/* File: logic/flow_decoder.sv */
// decode and execute of pc-relative branches and data-register compare
`timescale 1ns/1ps
module flow_decoder (
	input wire logic CLK_I, // processor clock
	input wire logic RST_B_I, // async reset, active low
	input wire flow_pkg::fetch_t FETCH_I, // instruction or extension word
	output logic FETCH_READY_O, // word taken when valid
	input wire flow_pkg::cmp_req_t CMP_I, // compare operands for current opcode
	input wire logic PUSH_READY_I, // stack memory accepts write
	output flow_pkg::push_t PUSH_O, // stack write request
	output logic [31:0] PC_O, // program counter
	output logic [31:0] SP_O, // stack pointer
	output flow_pkg::ccr_t CCR_O, // condition codes
	output logic JUMP_O, // pulse: pc redirected
	output logic ILLEGAL_O // pulse: opcode not handled here
);
	import flow_pkg::*;

	typedef enum {IDLE, EXT_HI, EXT_LO, PUSH} state_t;

	state_t state, next_state; // sequencing state
	logic [31:0] pc, next_pc; // address of the next word to fetch
	logic [31:0] base, next_base; // opcode address plus two
	logic [31:0] disp, next_disp; // collected displacement
	logic [3:0] cond, next_cond; // latched selector
	logic [31:0] sp, next_sp; // stack pointer
	ccr_t ccr, next_ccr; // condition codes
	push_t push, next_push; // stack write
	logic jump, next_jump; // redirect pulse
	logic illegal, next_illegal; // unknown opcode pulse
	logic taken; // selected condition true
	logic [3:0] sel; // selector under test: live word in idle, latched later
	logic wide, next_wide; // long form, upper half already held
	logic [32:0] diff; // compare difference with borrow
	logic sd, ss, sr; // sign bits at size

	// the selected test; taken from registers and inputs only, so no comb loop
	assign sel = (state == IDLE) ? FETCH_I.word[11:8] : cond;
	cond_test u_cond (
		.COND_I(sel),
		.CCR_I(ccr),
		.TRUE_O(taken)
	);

	// low-order subtraction at the selected size
	always_comb begin
		diff = 33'h0;
		sd = 1'b0;
		ss = 1'b0;
		sr = 1'b0;
		unique case (FETCH_I.word[8:6])
			SIZE_BYTE: begin
				diff = {24'h0, ({1'b0, CMP_I.dst[7:0]} - {1'b0, CMP_I.src[7:0]})};
				sd = CMP_I.dst[7];
				ss = CMP_I.src[7];
				sr = diff[7];
			end
			SIZE_WORD: begin
				diff = {16'h0, ({1'b0, CMP_I.dst[15:0]} - {1'b0, CMP_I.src[15:0]})};
				sd = CMP_I.dst[15];
				ss = CMP_I.src[15];
				sr = diff[15];
			end
			default: begin
				diff = {1'b0, CMP_I.dst} - {1'b0, CMP_I.src};
				sd = CMP_I.dst[31];
				ss = CMP_I.src[31];
				sr = diff[31];
			end
		endcase
	end

	// word accepted from the stream whenever not pushing
	assign FETCH_READY_O = (state != PUSH);

	// next-state and datapath
	always_comb begin
		logic [15:0] w;
		logic [31:0] tgt;
		w = FETCH_I.word;
		tgt = 32'h0;
		next_state = state;
		next_pc = pc;
		next_base = base;
		next_disp = disp;
		next_cond = cond;
		next_wide = wide;
		next_sp = sp;
		next_ccr = ccr;
		next_push = push;
		next_jump = 1'b0;
		next_illegal = 1'b0;
		if (push.valid && PUSH_READY_I) begin
			next_push.valid = 1'b0; // write taken
		end
		unique case (state)
			IDLE: begin
				if (FETCH_I.valid) begin
					next_pc = pc + EXT_STEP;
					next_base = pc + BASE_OFFSET;
					if (w[15:12] == BRANCH_GROUP) begin
						next_cond = w[11:8];
						if (w[7:0] == DISP_WORD_CODE) begin
							next_state = EXT_LO; // word form, also next-instruction case
							next_disp = 32'h0;
							next_wide = 1'b0; // low word is sign-extended
						end else if (w[7:0] == DISP_LONG_CODE) begin
							next_state = EXT_HI; // long form
							next_wide = 1'b1; // low word joins the upper half
						end else begin
							next_disp = {{24{w[7]}}, w[7:0]}; // signed byte
							next_state = IDLE;
							tgt = pc + BASE_OFFSET + next_disp;
							if (w[11:8] == COND_SUBROUTINE) begin
								next_state = PUSH;
							end else if (taken) begin
								next_pc = tgt;
								next_jump = 1'b1;
							end
						end
					end else if (w[15:12] == COMPARE_GROUP && !w[8] && w[7:6] != 2'h3) begin
						next_ccr.n = sr; // flags from result, x kept
						next_ccr.z = (w[8:6] == SIZE_BYTE) ? (diff[7:0] == 8'h0) :
							(w[8:6] == SIZE_WORD) ? (diff[15:0] == 16'h0) :
							(diff[31:0] == 32'h0);
						next_ccr.v = (sd ^ ss) & (sd ^ sr);
						next_ccr.c = (w[8:6] == SIZE_BYTE) ? diff[8] :
							(w[8:6] == SIZE_WORD) ? diff[16] : diff[32];
					end else begin
						next_illegal = 1'b1;
					end
				end
			end
			EXT_HI: begin
				if (FETCH_I.valid) begin
					next_pc = pc + EXT_STEP;
					next_disp = {w, 16'h0}; // upper half first
					next_state = EXT_LO;
				end
			end
			EXT_LO: begin
				if (FETCH_I.valid) begin
					next_pc = pc + EXT_STEP; // return address past extensions
					next_disp = wide ? {disp[31:16], w} : {{16{w[15]}}, w};
					tgt = base + next_disp;
					next_state = IDLE;
					if (cond == COND_SUBROUTINE) begin
						next_state = PUSH;
					end else if (taken) begin
						next_pc = tgt;
						next_jump = 1'b1;
					end
				end
			end
			PUSH: begin
				if (!push.valid) begin
					next_sp = sp - STACK_STEP;
					next_push.valid = 1'b1;
					next_push.addr = sp - STACK_STEP;
					next_push.data = pc; // following instruction
				end else if (PUSH_READY_I) begin
					next_pc = base + disp; // jump after write
					next_jump = 1'b1;
					next_state = IDLE;
				end
			end
		endcase
	end

	// register all state; branches never touch ccr
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state <= IDLE;
			pc <= PC_RESET;
			base <= PC_RESET;
			disp <= 32'h0;
			cond <= 4'h0;
			wide <= 1'b0;
			sp <= SP_RESET;
			ccr <= CCR_RESET;
			push <= '0;
			jump <= 1'b0;
			illegal <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			base <= next_base;
			disp <= next_disp;
			cond <= next_cond;
			wide <= next_wide;
			sp <= next_sp;
			ccr <= next_ccr;
			push <= next_push;
			jump <= next_jump;
			illegal <= next_illegal;
		end
	end

	assign PUSH_O = push;
	assign PC_O = pc;
	assign SP_O = sp;
	assign CCR_O = ccr;
	assign JUMP_O = jump;
	assign ILLEGAL_O = illegal;

	// an always branch with byte displacement jumps next cycle
	property p_always_jump;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state == IDLE && FETCH_I.valid && FETCH_I.word[15:8] == 8'h60 &&
			FETCH_I.word[7:0] != 8'h00 && FETCH_I.word[7:0] != 8'hff)
		|=> (JUMP_O && PC_O == $past(pc) + 32'h2 + {{24{$past(FETCH_I.word[7])}},
			$past(FETCH_I.word[7:0])});
	endproperty
	a_always_jump: assert property (p_always_jump) else $error("bad byte branch target");

	// zero byte displacement waits for a word extension
	property p_word_ext;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state == IDLE && FETCH_I.valid && FETCH_I.word[15:12] == 4'h6 &&
			FETCH_I.word[7:0] == 8'h00) |=> (state == EXT_LO && !JUMP_O);
	endproperty
	a_word_ext: assert property (p_word_ext) else $error("word form not taken");

	// all-ones displacement waits for the upper word
	property p_long_ext;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state == IDLE && FETCH_I.valid && FETCH_I.word[15:12] == 4'h6 &&
			FETCH_I.word[7:0] == 8'hff) |=> (state == EXT_HI);
	endproperty
	a_long_ext: assert property (p_long_ext) else $error("long form not taken");

	// flags hold through the extension and push states of a branch
	property p_ccr_hold;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state != IDLE) |=> $stable(CCR_O);
	endproperty
	a_ccr_hold: assert property (p_ccr_hold) else $error("branch changed flags");

	// push address is the stack pointer less four
	property p_push_addr;
		@(posedge CLK_I) disable iff (!RST_B_I)
		$rose(PUSH_O.valid) |-> (PUSH_O.addr == $past(sp) - 32'h4 && SP_O == PUSH_O.addr);
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("bad push address");

	// jump follows once the return address is written
	sequence s_push_done;
		PUSH_O.valid && PUSH_READY_I;
	endsequence
	property p_push_then_jump;
		@(posedge CLK_I) disable iff (!RST_B_I)
		((state == PUSH) and s_push_done) |=> (JUMP_O && state == IDLE);
	endproperty
	a_push_then_jump: assert property (p_push_then_jump) else $error("no jump after push");

	// compare keeps x
	property p_cmp_x;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state == IDLE && FETCH_I.valid && FETCH_I.word[15:12] == 4'hb) |=> $stable(CCR_O.x);
	endproperty
	a_cmp_x: assert property (p_cmp_x) else $error("compare changed x");

	// byte compare of equal low bytes sets zero
	property p_cmp_zero;
		@(posedge CLK_I) disable iff (!RST_B_I)
		(state == IDLE && FETCH_I.valid && FETCH_I.word[15:12] == 4'hb && !FETCH_I.word[8] &&
			FETCH_I.word[7:6] == 2'h0 && CMP_I.size == 3'h0 && CMP_I.dst[7:0] == CMP_I.src[7:0])
		|=> (CCR_O.z && !CCR_O.c);
	endproperty
	a_cmp_zero: assert property (p_cmp_zero) else $error("byte compare zero wrong");
endmodule

/* File: dv/stream_stack_model.sv */
// bench model of the instruction fetch stream and the stack memory
`timescale 1ns/1ps
module stream_stack_model (
	input wire logic clk_i, // processor clock
	input wire logic rst_b_i, // reset, active low
	input wire logic fetch_ready_i, // decoder takes words
	output flow_pkg::fetch_t fetch_o, // offered stream word
	input wire flow_pkg::push_t push_i, // stack write request
	output logic push_ready_o // stack write accepted
);
	import flow_pkg::*;
	logic [15:0] words[$]; // queued stream words
	logic [31:0] mem_addr; // last stored stack address
	logic [31:0] mem_data; // last stored stack data
	int stall = 0; // wait cycles before a push is accepted
	int waited = 0; // cycles the current push has waited
	initial begin
		fetch_o = '0;
		push_ready_o = 1'b0;
	end
	// queue a word for the stream
	task automatic put(input logic [15:0] w);
		words.push_back(w);
	endtask
	// drop the taken word, store the accepted push
	always @(posedge clk_i) begin
		if (fetch_o.valid && fetch_ready_i) begin
			void'(words.pop_front());
		end
		if (push_i.valid && push_ready_o) begin
			mem_addr <= push_i.addr;
			mem_data <= push_i.data;
		end
	end
	// offer head word; an idle line inverts the shown word every cycle
	always @(negedge clk_i) begin
		if (!rst_b_i) begin
			fetch_o <= '0;
		end else if (words.size() > 0) begin
			fetch_o <= {1'b1, words[0]};
		end else begin
			fetch_o <= {1'b0, ~fetch_o.word};
		end
		// slow memory: accept after stall cycles, for one cycle
		if (!push_i.valid || push_ready_o) begin
			waited <= 0;
			push_ready_o <= 1'b0;
		end else begin
			waited <= waited + 1;
			push_ready_o <= (waited >= stall);
		end
	end
endmodule

/* File: dv/pc_relative_branch_and_compare_tb_top.sv */
// self-checking bench for the branch and compare decoder
`timescale 1ns/1ps
module pc_relative_branch_and_compare_tb_top;
	import flow_pkg::*;
	logic clk = 1'b0; // processor clock
	logic rst_b = 1'b0; // reset, active low
	fetch_t fetch; // stream word
	logic fetch_ready; // word taken
	cmp_req_t cmp = '0; // compare operands
	logic push_ready; // stack accepts
	push_t push; // stack write
	logic [31:0] pc, sp; // program counter, stack pointer
	ccr_t ccr; // condition codes
	logic jump, illegal; // result pulses
	int miscompares = 0, samples_checked = 0, jumps = 0, illegals = 0;
	logic [31:0] jump_pc; // pc seen at last jump
	always #20 clk = ~clk;
	flow_decoder dut (.CLK_I(clk), .RST_B_I(rst_b), .FETCH_I(fetch),
		.FETCH_READY_O(fetch_ready), .CMP_I(cmp), .PUSH_READY_I(push_ready),
		.PUSH_O(push), .PC_O(pc), .SP_O(sp), .CCR_O(ccr), .JUMP_O(jump),
		.ILLEGAL_O(illegal));
	stream_stack_model fm (.clk_i(clk), .rst_b_i(rst_b), .fetch_ready_i(fetch_ready),
		.fetch_o(fetch), .push_i(push), .push_ready_o(push_ready));
	// count the one-cycle pulses
	always @(negedge clk) begin
		if (jump === 1'b1) begin
			jumps++;
			jump_pc = pc;
		end
		if (illegal === 1'b1) illegals++;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// wait until stream and stack stay idle three cycles
	task automatic settle();
		int i, quiet;
		quiet = 0;
		for (i = 0; i < 60 && quiet < 3; i++) begin
			@(negedge clk);
			quiet = (fm.words.size() == 0 && push.valid !== 1'b1) ? quiet + 1 : 0;
		end
		if (quiet < 3) begin
			chk("settle", 32'h1, 32'h0);
			conclude();
		end
	endtask
	// run one branch of n words and judge pc, pulse and flags
	task automatic br(input logic [15:0] op, e1, e2, input int n,
		input logic [31:0] disp, input bit take);
		logic [31:0] p;
		ccr_t c0;
		int j0;
		p = pc;
		c0 = ccr;
		j0 = jumps;
		fm.put(op);
		if (n > 1) fm.put(e1);
		if (n > 2) fm.put(e2);
		settle();
		chk("pc", take ? p + BASE_OFFSET + disp : p + 32'(2 * n), pc);
		chk("jumps", {31'h0, take}, 32'(jumps - j0));
		if (take) chk("jump pc", p + BASE_OFFSET + disp, jump_pc);
		chk("ccr", {27'h0, c0}, {27'h0, ccr});
	endtask
	// run one compare and judge the flags
	task automatic cmpop(input logic [2:0] size, input logic [31:0] d, s, input ccr_t e);
		cmp = '{size, d, s};
		fm.put({7'h58, size, 6'h00});
		settle();
		chk("ccr", {27'h0, e}, {27'h0, ccr});
	endtask
	task automatic t_bra();
		br(16'h60fe, 16'h0, 16'h0, 1, 32'hfffffffe, 1);
		br(16'h6010, 16'h0, 16'h0, 1, 32'h10, 1);
		br(16'h6000, 16'h0000, 16'h0, 2, 32'h0, 1);
		br(16'h6000, 16'hfff0, 16'h0, 2, 32'hfffffff0, 1);
		br(16'h60ff, 16'h0001, 16'h0004, 3, 32'h00010004, 1);
		br(16'h60ff, 16'h0000, 16'h8000, 3, 32'h00008000, 1);
		$display("test bra done");
	endtask
	task automatic t_cmp();
		cmpop(SIZE_BYTE, 32'h12345601, 32'h2, 5'h09);
		cmpop(SIZE_WORD, 32'h8000, 32'h1, 5'h02);
		cmpop(SIZE_LONG, 32'h7fffffff, 32'hffffffff, 5'h0b);
		cmpop(SIZE_BYTE, 32'hff000033, 32'h33, 5'h04);
		$display("test compare done");
	endtask
	// selectors 2 to 15 under two flag states
	task automatic t_cond();
		logic [15:0] ma, mb;
		ma = 16'ha968;
		mb = 16'h9598;
		cmpop(SIZE_BYTE, 32'h1, 32'h2, 5'h09);
		for (int c = 2; c < 16; c++) br({4'h6, 4'(c), 8'h04}, 0, 0, 1, 4, ma[c]);
		cmpop(SIZE_LONG, 32'h5, 32'h5, 5'h04);
		for (int c = 2; c < 16; c++) br({4'h6, 4'(c), 8'h04}, 0, 0, 1, 4, mb[c]);
		br(16'h6700, 16'h0020, 16'h0, 2, 32'h20, 1);
		$display("test condition done");
	endtask
	task automatic t_bsr();
		logic [31:0] p, s;
		fm.stall = 3;
		p = pc;
		s = sp;
		br(16'h6108, 16'h0, 16'h0, 1, 32'h8, 1);
		chk("sp", s - STACK_STEP, sp);
		chk("push addr", s - STACK_STEP, fm.mem_addr);
		chk("push data", p + 32'h2, fm.mem_data);
		p = pc;
		br(16'h61ff, 16'hffff, 16'hfff0, 3, 32'hfffffff0, 1);
		chk("push addr", s - 32'h8, fm.mem_addr);
		chk("push data", p + 32'h6, fm.mem_data);
		$display("test subroutine done");
	endtask
	task automatic t_ill();
		int i0;
		i0 = illegals;
		fm.put(16'h4e71);
		fm.put(16'hb0c0);
		settle();
		chk("illegal", 32'h2, 32'(illegals - i0));
		$display("test illegal done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk("pc", PC_RESET, pc);
		chk("sp", SP_RESET, sp);
		t_bra();
		t_cmp();
		t_cond();
		t_bsr();
		t_ill();
		conclude();
	end
endmodule
